//--- logic/sefb_cfg.svh
/*
 * offsets, field positions, reset values, command codes and frame lengths
 * of the serial error-flag, burst and reset-key register bank.
 * assumes it is included by its bare name from the design files.
 */
`ifndef SEFB_CFG_SVH
`define SEFB_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register addresses (7-bit)
`define SEFB_ADDR_SWITCH 7'h01
`define SEFB_ADDR_ERR_CFG 7'h02
`define SEFB_ADDR_FLAGS 7'h03
`define SEFB_ADDR_BURST 7'h05
`define SEFB_ADDR_KEY 7'h0B

////////////////////////////////////////////////////////////////////////////////
// reset values
`define SEFB_RST_SWITCH 4'h0
`define SEFB_RST_ERR_CFG 3'h6
`define SEFB_RST_FLAGS 3'h0
`define SEFB_RST_BURST 1'h0

////////////////////////////////////////////////////////////////////////////////
// field positions in error config and error flags
`define SEFB_BIT_CRC 0
`define SEFB_BIT_SCLK 1
`define SEFB_BIT_RW 2

////////////////////////////////////////////////////////////////////////////////
// commands, key values, frame shape
`define SEFB_CLEAR_CMD 16'h6CA9
`define SEFB_KEY_FIRST 8'hA3
`define SEFB_KEY_SECOND 8'h05
`define SEFB_LEN_PLAIN 5'h10
`define SEFB_LEN_CRC 5'h18
`define SEFB_ADDR_BITS 5'h08
`define SEFB_CRC_POLY 8'h07
`define SEFB_CRC_INIT 8'h00

`endif

//--- logic/sefb_pkg.sv
/*
 * types shared by the register bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sefb_pkg;

    typedef enum logic {
        SEFB_IDLE,
        SEFB_FRAME
    } sefb_link_t;

    typedef logic [7:0] sefb_byte_t;

endpackage

//--- logic/sefb_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes the inputs are quasi-static with respect to clk.
 */
module sefb_sync #(
    parameter int W = 3
) (
    // system
    input wire logic clk,
    input wire logic srst,
    // pins and synchronised copies
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    generate
        if (W < 1) begin : g_bad_width
            $error("sefb_sync: width must be at least one");
        end
    endgenerate

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

//--- logic/sefb_top.sv
/*
 * mode-0 serial slave with error flags, burst gating and a two-write reset key.
 * assumes the controller runs the serial clock well below clk/8 and keeps
 * chip select high between non-burst frames.
 */
// Summary of operation
// - the 16-bit clear command zeroes every error flag.
// - the clear command never raises the bad-address flag.
// - with checksum on, the clear only acts when its checksum byte matches.
// - a read of an unimplemented address raises the bad-address flag, bit 2.
// - a write to an unimplemented or read-only address raises bad-address too.
// - a frame ending with the wrong clock count raises flag bit 1.
// - a write with a mismatching checksum raises flag bit 0.
// - flags are read-only at 0x03, reset 0x00, bits 7..3 read zero.
// - with burst on, several frames run under one chip-select low period.
// - burst enable is bit 0 at 0x05, resets off, bits 7..1 read zero.
// - writing 0xA3 then 0x05 to 0x0B returns all registers to defaults.
// - clock count is 16, or 24 with checksum; multiples of those in burst.
// - with checksum on, frames are 24 bits: command then checksum byte.
// - each flag sets only while its detection is enabled; clock-count and bad-address on by default.
`include "sefb_cfg.svh"

module sefb_top (
    // system
    input wire logic clk,
    input wire logic srst,
    // serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // device state
    output logic [3:0] switch_en,
    output logic [2:0] error_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [2:0] pin_q;
    logic sclk_s, cs_s, sdi_s, sclk_d;
    logic sclk_rise, sclk_fall;

    sefb_sync #(.W(3)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({sclk, ~cs_n, sdi}),
        .q(pin_q)
    );

    // select enters inverted: the zero reset of the synchroniser reads as
    // deselected, so no false frame follows reset
    assign sclk_s = pin_q[2];
    assign cs_s = ~pin_q[1];
    assign sdi_s = pin_q[0];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic sefb_pkg::sefb_byte_t crc_step(input sefb_pkg::sefb_byte_t c,
                                                      input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SEFB_CRC_POLY : 8'h00);
    endfunction

    // address decode shared by the read path and the commit path
    function automatic logic addr_ok(input logic [6:0] a, input logic wr);
        case (a)
            `SEFB_ADDR_SWITCH, `SEFB_ADDR_ERR_CFG, `SEFB_ADDR_BURST,
            `SEFB_ADDR_KEY: addr_ok = 1'b1;
            `SEFB_ADDR_FLAGS: addr_ok = ~wr;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    sefb_pkg::sefb_link_t link_st, next_link_st;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [1:0] frames, next_frames;
    logic [22:0] shift_in, next_shift_in;
    sefb_pkg::sefb_byte_t crc, next_crc;
    sefb_pkg::sefb_byte_t out_sr, next_out_sr;
    logic [15:0] pend_cmd, next_pend_cmd;
    logic pend_bad, next_pend_bad, pend_v, next_pend_v;
    logic [3:0] reg_switch, next_reg_switch;
    logic [2:0] reg_cfg, next_reg_cfg;
    logic [2:0] reg_flags, next_reg_flags;
    logic reg_burst, next_reg_burst;
    logic key_armed, next_key_armed;

    logic [4:0] frame_len;
    logic [23:0] word;
    logic commit, commit_bad, commit_wr, clr, soft_rst;
    logic [15:0] commit_cmd;
    logic [2:0] set_flags;
    logic [6:0] rd_addr, c_addr;
    sefb_pkg::sefb_byte_t rd_data, c_data;

    assign frame_len = reg_cfg[`SEFB_BIT_CRC] ? `SEFB_LEN_CRC : `SEFB_LEN_PLAIN;
    assign word = {shift_in, sdi_s};
    assign rd_addr = shift_in[6:0];
    assign c_addr = commit_cmd[14:8];
    assign c_data = commit_cmd[7:0];
    assign commit_wr = ~commit_cmd[15];

    // read mux, unused bits read as zero
    always_comb begin
        rd_data = 8'h00;
        case (rd_addr)
            `SEFB_ADDR_SWITCH: rd_data = {4'h0, reg_switch};
            `SEFB_ADDR_ERR_CFG: rd_data = {5'h00, reg_cfg};
            `SEFB_ADDR_FLAGS: rd_data = {5'h00, reg_flags};
            `SEFB_ADDR_BURST: rd_data = {7'h00, reg_burst};
            default: rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        next_link_st = link_st;
        next_bit_cnt = bit_cnt;
        next_frames = frames;
        next_shift_in = shift_in;
        next_crc = crc;
        next_out_sr = out_sr;
        next_pend_cmd = pend_cmd;
        next_pend_bad = pend_bad;
        next_pend_v = pend_v;
        next_reg_switch = reg_switch;
        next_reg_cfg = reg_cfg;
        next_reg_burst = reg_burst;
        next_key_armed = key_armed;
        commit = 1'b0;
        commit_cmd = pend_cmd;
        commit_bad = pend_bad;
        set_flags = 3'h0;
        clr = 1'b0;
        soft_rst = 1'b0;

        case (link_st)
            sefb_pkg::SEFB_IDLE: begin
                if (!cs_s) begin
                    next_link_st = sefb_pkg::SEFB_FRAME;
                    next_bit_cnt = 5'h00;
                    next_frames = 2'h0;
                    next_out_sr = 8'h00;
                    next_pend_v = 1'b0;
                end
            end
            sefb_pkg::SEFB_FRAME: begin
                if (cs_s) begin
                    next_link_st = sefb_pkg::SEFB_IDLE;
                    next_pend_v = 1'b0;
                    // partial frame or wrong frame count discards the command
                    if (bit_cnt != 5'h00 || frames == 2'h0 ||
                        (!reg_burst && frames != 2'h1)) begin
                        set_flags[`SEFB_BIT_SCLK] = reg_cfg[`SEFB_BIT_SCLK];
                    end else if (!reg_burst && pend_v) begin
                        commit = 1'b1;
                    end
                end else begin
                    if (sclk_rise) begin
                        next_shift_in = word[22:0];
                        if (bit_cnt < `SEFB_LEN_PLAIN) begin
                            next_crc = crc_step((bit_cnt == 5'h00) ? `SEFB_CRC_INIT : crc,
                                                sdi_s);
                        end
                        if (bit_cnt == frame_len - 5'h01) begin
                            next_bit_cnt = 5'h00;
                            next_frames = (frames == 2'h2) ? frames : frames + 2'h1;
                            next_pend_cmd = reg_cfg[`SEFB_BIT_CRC] ? word[23:8] : word[15:0];
                            next_pend_bad = reg_cfg[`SEFB_BIT_CRC] && (word[7:0] != crc);
                            next_pend_v = 1'b1;
                            // burst commits each frame as soon as it completes
                            if (reg_burst) begin
                                commit = 1'b1;
                                commit_cmd = next_pend_cmd;
                                commit_bad = next_pend_bad;
                            end
                        end else begin
                            next_bit_cnt = bit_cnt + 5'h01;
                        end
                    end
                    if (sclk_fall) begin
                        if (bit_cnt == `SEFB_ADDR_BITS) begin
                            next_out_sr = (shift_in[7] && addr_ok(rd_addr, 1'b0)) ?
                                          rd_data : 8'h00;
                        end else begin
                            next_out_sr = {out_sr[6:0], 1'b0};
                        end
                    end
                end
            end
            default: next_link_st = sefb_pkg::SEFB_IDLE;
        endcase

        if (commit) begin
            if (commit_bad) begin
                // a failed checksum also blocks the clear command
                set_flags[`SEFB_BIT_CRC] = commit_wr;
            end else if (commit_cmd == `SEFB_CLEAR_CMD) begin
                clr = 1'b1;
            end else if (!addr_ok(c_addr, commit_wr)) begin
                set_flags[`SEFB_BIT_RW] = reg_cfg[`SEFB_BIT_RW];
            end else if (commit_wr) begin
                next_key_armed = 1'b0;
                case (c_addr)
                    `SEFB_ADDR_SWITCH: next_reg_switch = c_data[3:0];
                    `SEFB_ADDR_ERR_CFG: next_reg_cfg = c_data[2:0];
                    `SEFB_ADDR_BURST: next_reg_burst = c_data[0];
                    `SEFB_ADDR_KEY: begin
                        if (key_armed && c_data == `SEFB_KEY_SECOND) begin
                            soft_rst = 1'b1;
                        end else begin
                            // any other value re-arms only on the first key
                            next_key_armed = (c_data == `SEFB_KEY_FIRST);
                        end
                    end
                    default: next_key_armed = 1'b0;
                endcase
            end
        end

        // set wins over clear; flags otherwise hold
        next_reg_flags = ((clr ? 3'h0 : reg_flags) | set_flags);
        if (soft_rst) begin
            next_reg_switch = `SEFB_RST_SWITCH;
            next_reg_cfg = `SEFB_RST_ERR_CFG;
            next_reg_flags = `SEFB_RST_FLAGS;
            next_reg_burst = `SEFB_RST_BURST;
            next_key_armed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (srst) begin
            link_st <= sefb_pkg::SEFB_IDLE;
            sclk_d <= 1'b0;
            bit_cnt <= 5'h00;
            frames <= 2'h0;
            shift_in <= 23'h000000;
            crc <= `SEFB_CRC_INIT;
            out_sr <= 8'h00;
            pend_cmd <= 16'h0000;
            pend_bad <= 1'b0;
            pend_v <= 1'b0;
            reg_switch <= `SEFB_RST_SWITCH;
            reg_cfg <= `SEFB_RST_ERR_CFG;
            reg_flags <= `SEFB_RST_FLAGS;
            reg_burst <= `SEFB_RST_BURST;
            key_armed <= 1'b0;
        end else begin
            link_st <= next_link_st;
            sclk_d <= sclk_s;
            bit_cnt <= next_bit_cnt;
            frames <= next_frames;
            shift_in <= next_shift_in;
            crc <= next_crc;
            out_sr <= next_out_sr;
            pend_cmd <= next_pend_cmd;
            pend_bad <= next_pend_bad;
            pend_v <= next_pend_v;
            reg_switch <= next_reg_switch;
            reg_cfg <= next_reg_cfg;
            reg_flags <= next_reg_flags;
            reg_burst <= next_reg_burst;
            key_armed <= next_key_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sdo = out_sr[7];
    assign sdo_oe = ~cs_s;
    assign switch_en = reg_switch;
    assign error_flags = reg_flags;

endmodule

//--- tb/sefb_top_chk.sv
/*
 * port checker for the serial register bank.
 * assumes a bind to sefb_top and the single clk domain.
 */
module sefb_chk (
    // system
    input wire logic clk,
    input wire logic srst,
    // link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // device state
    input wire logic [3:0] switch_en,
    input wire logic [2:0] error_flags
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic [1:0] pins_d;
    logic [1:0] next_pins_d;

    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the last link pin edge; state may only move shortly after one
    always_comb begin
        next_pins_d = {sclk, cs_n};
        next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
        if (srst || pins_d != next_pins_d) begin
            next_quiet = 4'h0;
        end
    end
    always_ff @(posedge clk) begin
        quiet <= next_quiet;
        pins_d <= next_pins_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_flags_idle_hold: assert property (!$stable(error_flags) |-> quiet < 4'hA)
        else $error("flags moved with the link idle");
    a_switch_idle_hold: assert property (!$stable(switch_en) |-> quiet < 4'hA)
        else $error("switch moved with the link idle");
    a_sdo_idle_hold: assert property (!$stable(sdo) |-> quiet < 4'hA)
        else $error("sdo moved with the link idle");
    a_oe_turn_on: assert property ($fell(cs_n) |-> ##[1:4] sdo_oe)
        else $error("sdo not driven after select");
    a_oe_turn_off: assert property ($rose(cs_n) |-> ##[1:4] !sdo_oe)
        else $error("sdo still driven after deselect");
    a_oe_held_on: assert property ((!cs_n) [*5] |-> sdo_oe)
        else $error("sdo dropped while selected");
    a_oe_held_off: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    a_reset_zero_state: assert property ($fell(srst) |->
        error_flags == 3'h0 && switch_en == 4'h0)
        else $error("state not cleared by reset");

    c_addr_flag: cover property ($rose(error_flags[2]));
    c_count_flag: cover property ($rose(error_flags[1]));
    c_crc_clear: cover property ($fell(error_flags[0]));
endmodule

bind sefb_top sefb_chk i_sefb_chk (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .switch_en(switch_en), .error_flags(error_flags));

//--- tb/sefb_spi_ctl.sv
/*
 * mode-0 serial controller model, 160 ns serial period.
 * assumes the 100 MHz system clock as its time base.
 */
module sefb_spi_ctl (
    // system
    input wire logic clk,
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end

    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask

    // checksum byte, poly 0x07, init 0x00, msb first
    function automatic logic [7:0] crc8(input logic [15:0] c);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ c[i]) ? 8'h07 : 8'h00);
        end
        return r;
    endfunction

    // hold keeps select low for the next burst frame
    task automatic frame(input logic [23:0] w, input int n, input bit hold, output logic [7:0] rd);
        rd = 8'h00;
        if (cs_n) begin
            cs_n = 1'b0;
            half();
        end
        for (int i = 0; i < n; i++) begin
            sdi = w[n-1-i];
            half();
            sclk = 1'b1;
            if (i >= 8 && i < 16) begin
                rd = {rd[6:0], sdo};
            end
            half();
            sclk = 1'b0;
        end
        if (!hold) begin
            half();
            cs_n = 1'b1;
            // a released line must not keep its last level
            sdi = ~sdi;
            half();
        end
    endtask
endmodule

//--- tb/sefb_top_tb.sv
/*
 * self-checking bench for the serial register bank.
 * assumes sefb_top, the controller model and the checker are compiled first.
 */
module sefb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, cs_n, sdi, sdo, sdo_oe;
    logic [3:0] switch_en;
    logic [2:0] error_flags;
    logic [7:0] rd;
    logic [20:0] bad_a = {7'h00, 7'h04, 7'h7F};
    bit crc_on = 1'b0;
    int bad_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    sefb_top i_sefb_top (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .switch_en(switch_en), .error_flags(error_flags));
    sefb_spi_ctl i_sefb_spi_ctl (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_flags(input logic [2:0] e);
        chk({5'h00, error_flags}, {5'h00, e});
    endtask
    task automatic chk_sw(input logic [3:0] e);
        chk({4'h0, switch_en}, {4'h0, e});
    endtask
    // n of 0 means the proper length; bad spoils the checksum
    task automatic cmd(input logic [15:0] c, input bit bad = 0, input bit hold = 0,
                       input int n = 0);
        logic [7:0] k;
        k = i_sefb_spi_ctl.crc8(c) ^ {7'h00, bad};
        if (n == 0) n = crc_on ? 24 : 16;
        i_sefb_spi_ctl.frame(crc_on ? {c, k} : {8'h00, c}, n, hold, rd);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input bit bad = 0);
        cmd({1'b0, a, d}, bad);
    endtask
    task automatic rdx(input logic [6:0] a, input logic [7:0] exp);
        cmd({1'b1, a, 8'h00});
        chk(rd, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        #1 cmd(16'h6CA9);
        chk_flags(3'h0);
        rdx(7'h03, 8'h00);
        rdx(7'h05, 8'h00);
        rdx(7'h02, 8'h06);
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            rdx(bad_a[i*7 +: 7], 8'h00);
            chk_flags(3'h4);
            cmd(16'h6CA9);
            chk_flags(3'h0);
        end
        wr(7'h03, 8'hFF);
        rdx(7'h03, 8'h04);
        cmd(16'h6CA9);
        $display("test bad address done");
        cmd(16'h010F, 0, 0, 15);
        chk_sw(4'h0);
        wr(7'h01, 8'h09);
        chk_flags(3'h2);
        chk_sw(4'h9);
        cmd(16'h6CA9);
        wr(7'h02, 8'h00);
        rdx(7'h04, 8'h00);
        cmd(16'h010F, 0, 0, 17);
        chk_flags(3'h0);
        wr(7'h02, 8'h07);
        crc_on = 1'b1;
        $display("test clock count done");
        wr(7'h01, 8'h05);
        chk_sw(4'h5);
        wr(7'h01, 8'h0A, 1);
        chk_sw(4'h5);
        chk_flags(3'h1);
        cmd(16'h6CA9, 1);
        chk_flags(3'h1);
        cmd(16'h6CA9);
        chk_flags(3'h0);
        cmd(16'h0103, 0, 0, 16);
        chk_flags(3'h2);
        cmd(16'h6CA9);
        wr(7'h02, 8'h06);
        crc_on = 1'b0;
        $display("test checksum done");
        wr(7'h05, 8'hFF);
        rdx(7'h05, 8'h01);
        cmd(16'h010C, 0, 1);
        cmd(16'h8100, 0, 1);
        chk(rd, 8'h0C);
        cmd(16'h0103);
        chk_sw(4'h3);
        chk_flags(3'h0);
        wr(7'h05, 8'h00);
        cmd(16'h0106, 0, 1);
        cmd(16'h0107);
        chk_flags(3'h2);
        chk_sw(4'h3);
        $display("test burst done");
        wr(7'h02, 8'h07);
        crc_on = 1'b1;
        wr(7'h0B, 8'hA3);
        wr(7'h0B, 8'h07);
        wr(7'h0B, 8'h05);
        chk_sw(4'h3);
        wr(7'h0B, 8'hA3);
        wr(7'h0B, 8'h05);
        // the key write restores the plain frame length
        crc_on = 1'b0;
        chk_sw(4'h0);
        chk_flags(3'h0);
        rdx(7'h02, 8'h06);
        rdx(7'h0B, 8'h00);
        $display("test reset key done");
        complete_run();
    end
endmodule
